// ### inc/float_wait_pkg.sv
package float_wait_pkg;
  localparam int NUM_CS = 4;
  localparam int CYCLE_W = 4;
  localparam logic [3:0] FLOAT_MAX = 4'hF;
  localparam logic [3:0] FLOAT_RESET = 4'h0;
  localparam logic READ_MODE_STROBE = 1'b1;
  localparam logic READ_MODE_SELECT = 1'b0;
  typedef enum logic [1:0] {ACC_NONE, ACC_READ, ACC_WRITE} acc_kind_t;
endpackage

// ### core/float_counter.sv
`timescale 1ns/1ps
// per-chip-select float period down counter
module float_counter
  import float_wait_pkg::*;
#(
  parameter int W = CYCLE_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [W-1:0] load,
  output logic busy
);
  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;

  assign count_next = start ? load : (count_reg != '0 ? count_reg - 1'b1 : count_reg);
  assign busy = (count_reg != '0);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  a_count_loads: assert property (@(posedge clk) disable iff (!rst_n)
    start |=> count_reg == $past(load)) else $error("float count did not load");
endmodule

// ### core/data_float_wait.sv
`timescale 1ns/1ps
// How it works
// - each chip select keeps a float cycle count between 0 and 15
// - after a read, wait the float count before reading another external device
// - after a read, wait the float count before any external write
// - internal accesses never wait on a pending float period
// - strobe mode: float period starts at read strobe rising edge
// - select mode: bus busy for the count after chip select rises, if it rises no later than the read strobe
// - per chip select, read mode and optimisation select choose float handling
module data_float_wait
  import float_wait_pkg::*;
#(
  parameter int N = NUM_CS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [N*CYCLE_W-1:0] float_cycle_count,
  input wire logic [N-1:0] read_mode_sel,
  input wire logic [N-1:0] float_optimisation_select,
  input wire logic req_valid,
  input wire logic req_external,
  input wire logic req_write,
  input wire logic [$clog2(N)-1:0] req_cs,
  output logic req_ready,
  input wire logic read_strobe_n,
  input wire logic [N-1:0] chip_select_n,
  output logic data_drive_allowed
);
  logic [N-1:0] busy;
  logic [N-1:0] start;
  logic read_strobe_n_meta_reg;
  logic read_strobe_n_sync_reg;
  logic read_strobe_n_prev_reg;
  logic [N-1:0] cs_n_meta_reg;
  logic [N-1:0] cs_n_sync_reg;
  logic [N-1:0] cs_n_prev_reg;
  logic [N-1:0] read_cs_reg;
  logic [N-1:0] read_cs_next;
  logic strobe_rise;
  logic [N-1:0] cs_rise;
  logic [N-1:0] block_vec;
  logic any_busy;
  logic conflict;
  logic read_active;
  logic [N-1:0] read_seen;
  logic [N-1:0] read_ends;
  logic [N-1:0] read_kept;
  logic ext_request;
  logic req_is_read;
  logic [N-1:0] req_onehot;
  logic [N-1:0] other_busy;
  logic [N-1:0] same_busy;
  logic other_read_blocked;
  logic same_unoptimised;
  logic optimised_same_only;
  logic [N-1:0] load_nonzero;

  // two-stage synchroniser for the read strobe pin
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      read_strobe_n_meta_reg <= 1'b1;
      read_strobe_n_sync_reg <= 1'b1;
    end else begin
      read_strobe_n_meta_reg <= read_strobe_n;
      read_strobe_n_sync_reg <= read_strobe_n_meta_reg;
    end
  end

  // two-stage synchroniser for the chip select pins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_n_meta_reg <= '1;
      cs_n_sync_reg <= '1;
    end else begin
      cs_n_meta_reg <= chip_select_n;
      cs_n_sync_reg <= cs_n_meta_reg;
    end
  end

  // previous levels for edge detection; idle high so reset gives no false edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      read_strobe_n_prev_reg <= 1'b1;
      cs_n_prev_reg <= '1;
    end else begin
      read_strobe_n_prev_reg <= read_strobe_n_sync_reg;
      cs_n_prev_reg <= cs_n_sync_reg;
    end
  end

  assign strobe_rise = read_strobe_n_sync_reg & ~read_strobe_n_prev_reg;
  assign cs_rise = cs_n_sync_reg & ~cs_n_prev_reg;

  // remember which selects took part in a read (strobe low while selected)
  assign read_active = ~read_strobe_n_sync_reg;
  assign read_seen = read_cs_reg | ~cs_n_sync_reg;
  assign read_ends = cs_rise | {N{strobe_rise}};
  assign read_kept = read_cs_reg & ~read_ends;
  assign read_cs_next = read_active ? read_seen : read_kept;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      read_cs_reg <= '0;
    end else begin
      read_cs_reg <= read_cs_next;
    end
  end

  sequence s_float_opens(logic opened, logic nonzero);
    opened && nonzero;
  endsequence

  sequence s_float_closes(logic running);
    $fell(running);
  endsequence

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_cs
      logic [CYCLE_W-1:0] armed_reg;
      logic [CYCLE_W-1:0] armed_next;
      logic [CYCLE_W:0] span_reg;
      logic [CYCLE_W:0] span_next;
      logic [CYCLE_W:0] span_step;

      // mode chooses the edge that opens the float period
      assign start[g] = read_cs_reg[g] &
        (read_mode_sel[g] == READ_MODE_STROBE ? strobe_rise : cs_rise[g]);
      float_counter #(.W(CYCLE_W)) u_cnt (
        .clk(clk),
        .rst_n(rst_n),
        .start(start[g]),
        .load(float_cycle_count[g*CYCLE_W +: CYCLE_W]),
        .busy(busy[g])
      );
      // optimised: a read of the same device need not wait
      assign block_vec[g] = busy[g] &
        (req_write | (g != int'(req_cs)) | ~float_optimisation_select[g]);

      // check-only tracker: length of the running float period
      assign load_nonzero[g] = |float_cycle_count[g*CYCLE_W +: CYCLE_W];
      assign armed_next = start[g] ? float_cycle_count[g*CYCLE_W +: CYCLE_W] : armed_reg;
      assign span_step = busy[g] ? span_reg + (CYCLE_W+1)'(1) : span_reg;
      assign span_next = start[g] ? '0 : span_step;

      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          armed_reg <= FLOAT_RESET;
          span_reg <= '0;
        end else begin
          armed_reg <= armed_next;
          span_reg <= span_next;
        end
      end

      a_float_opens: assert property (@(posedge clk) disable iff (!rst_n)
        s_float_opens(start[g], load_nonzero[g]) |=> busy[g])
        else $error("float period not opened");

      a_float_span: assert property (@(posedge clk) disable iff (!rst_n)
        s_float_closes(busy[g]) |-> span_reg == {1'b0, armed_reg})
        else $error("float period length wrong");

      a_float_ceiling: assert property (@(posedge clk) disable iff (!rst_n)
        span_reg <= {1'b0, FLOAT_MAX})
        else $error("float period too long");
    end
  endgenerate

  assign any_busy = |busy;
  assign ext_request = req_valid & req_external;
  assign req_is_read = ~req_write;
  assign req_onehot = N'(1) << req_cs;
  assign other_busy = busy & ~req_onehot;
  assign same_busy = busy & req_onehot;
  assign other_read_blocked = |other_busy;
  assign same_unoptimised = |(same_busy & ~float_optimisation_select);
  assign optimised_same_only = ~other_read_blocked & (|(same_busy & float_optimisation_select));
  assign conflict = ext_request & (|block_vec);
  assign req_ready = ~conflict;
  assign data_drive_allowed = ~any_busy;

  a_internal_free: assert property (@(posedge clk) disable iff (!rst_n)
    !req_external |-> req_ready) else $error("internal access stalled");

  a_write_waits: assert property (@(posedge clk) disable iff (!rst_n)
    (ext_request && req_write && any_busy) |-> !req_ready)
    else $error("write started during float");

  a_write_same_waits: assert property (@(posedge clk) disable iff (!rst_n)
    (ext_request && req_write && (|same_busy)) |-> !req_ready)
    else $error("write to same device during float");

  a_read_other_waits: assert property (@(posedge clk) disable iff (!rst_n)
    (ext_request && req_is_read && other_read_blocked) |-> !req_ready)
    else $error("read of other device during float");

  a_read_same_waits: assert property (@(posedge clk) disable iff (!rst_n)
    (ext_request && req_is_read && same_unoptimised) |-> !req_ready)
    else $error("unoptimised same read during float");

  a_optimised_read: assert property (@(posedge clk) disable iff (!rst_n)
    (ext_request && req_is_read && optimised_same_only) |-> req_ready)
    else $error("optimised same read stalled");

  a_no_drive: assert property (@(posedge clk) disable iff (!rst_n)
    any_busy |-> !data_drive_allowed) else $error("bus driven during float");

  a_strobe_start: assert property (@(posedge clk) disable iff (!rst_n)
    (strobe_rise && read_cs_reg[0] && read_mode_sel[0] && float_cycle_count[3:0] != 4'h0)
    |=> busy[0]) else $error("strobe float not started");

  a_expiry_frees: assert property (@(posedge clk) disable iff (!rst_n)
    s_float_closes(any_busy) |-> req_ready && data_drive_allowed)
    else $error("access held after float expiry");
endmodule

// ### test/ext_memory_model.sv
`timescale 1ns/1ps
// slow memory: one read, then strobe and select released together
module ext_memory_model (
  input wire logic clk,
  output logic read_strobe_n,
  output logic [3:0] chip_select_n
);
  initial begin
    read_strobe_n = 1'b1;
    chip_select_n = 4'hF;
  end
  task automatic read_cycle(input logic [1:0] cs);
    chip_select_n[cs] = 1'b0;
    read_strobe_n = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    read_strobe_n = 1'b1;
    chip_select_n = 4'hF;
  endtask
endmodule

// ### test/data_float_wait_tb.sv
`timescale 1ns/1ps
module data_float_wait_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic req_external = 1'b1;
  logic req_write = 1'b0;
  logic [1:0] req_cs = 2'h0;
  logic req_ready, data_drive_allowed, read_strobe_n;
  logic [3:0] chip_select_n;
  int n_mismatch = 0;
  int n_checks = 0;
  initial forever #10 clk = ~clk;
  ext_memory_model mem (.clk(clk), .read_strobe_n(read_strobe_n),
    .chip_select_n(chip_select_n));
  // counts cs3..cs0 = 5,15,0,3; cs0 strobe mode; cs2 optimised
  data_float_wait dut (.clk(clk), .rst_n(rst_n), .float_cycle_count(16'h5F03),
    .read_mode_sel(4'h1), .float_optimisation_select(4'h4), .req_valid(1'b1),
    .req_external(req_external), .req_write(req_write), .req_cs(req_cs),
    .req_ready(req_ready), .read_strobe_n(read_strobe_n),
    .chip_select_n(chip_select_n), .data_drive_allowed(data_drive_allowed));
  task automatic run(input logic [1:0] rd, tgt, input logic ext, wr, input int w, d);
    int lo;
    int dlo;
    lo = 0;
    dlo = 0;
    req_cs = tgt;
    req_external = ext;
    req_write = wr;
    mem.read_cycle(rd);
    repeat (24) begin
      @(posedge clk);
      #1;
      lo += (req_ready !== 1'b1);
      dlo += (data_drive_allowed !== 1'b1);
    end
    n_checks += 2;
    if (lo != w || dlo != d) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t wait %0d drive %0d", $time, lo, dlo);
    end
    $display("test done rd=%0d tgt=%0d", rd, tgt);
  endtask
  task automatic t_write; run(2'h0, 2'h0, 1'b1, 1'b1, 3, 3); endtask
  task automatic t_other; run(2'h3, 2'h1, 1'b1, 1'b0, 5, 5); endtask
  task automatic t_zero; run(2'h1, 2'h0, 1'b1, 1'b1, 0, 0); endtask
  task automatic t_same; run(2'h2, 2'h2, 1'b1, 1'b0, 0, 15); endtask
  task automatic t_max; run(2'h2, 2'h2, 1'b1, 1'b1, 15, 15); endtask
  task automatic t_int; run(2'h2, 2'h1, 1'b0, 1'b1, 0, 15); endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    #1;
    rst_n = 1'b1;
    @(posedge clk);
    #1;
    t_write();
    t_other();
    t_zero();
    t_same();
    t_max();
    t_int();
    summarize();
  end
  initial begin
    #20000;
    n_mismatch++;
    summarize();
  end
endmodule
